// ### rtl/tcm_timer.sv
// Eight-bit timer with flags, mask and compare output modulator on AXI4-Lite.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
module tcm_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic global_irq_enable,
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    input wire logic legacy_mode_fuse,
    input wire logic wide_timer_channel_c_output,
    input wire logic wide_timer_compare_mode_on,
    input wire logic external_count_input,
    output logic compare_irq_req,
    output logic overflow_irq_req,
    output logic compare_wave_output,
    output logic shared_output_pin_o,
    output logic shared_output_pin_oe
);
    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8 to reach every register.");
    end

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_have;
        logic w_have;
        logic [5:0] aw_idx;
        logic [7:0] w_byte;
        logic w_lane0;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] ctrl;
        logic [7:0] count;
        logic [7:0] compare;
        logic [7:0] port;
        logic block_cmp;
        logic count_down;
        logic oc;
        logic cmp_irq;
        logic ovf_irq;
        logic pin_o;
        logic pin_oe;
    } tcm_timer_state_t;

    tcm_timer_state_t s;
    tcm_timer_state_t next_s;
    logic tick;
    logic do_write;
    logic idx_known;
    logic [5:0] ar_idx;
    logic ar_known;
    logic wr_count;
    logic wr_ctrl;
    logic match;
    logic cmp_event;
    logic ovf_event;
    logic force_cmp;
    logic oc_en;
    logic mod_on;
    logic [1:0] com;
    tcm_pkg::tcm_wave_t wave;

    tcm_clk_sel u_clk_sel (
        .aclk(aclk),
        .aresetn(aresetn),
        .clock_select(s.ctrl[tcm_pkg::CTRL_CS_HI:tcm_pkg::CTRL_CS_LO]),
        .external_count_input(external_count_input),
        .count_tick(tick)
    );

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;
    assign compare_irq_req = s.cmp_irq;
    assign overflow_irq_req = s.ovf_irq;
    assign compare_wave_output = s.oc;
    assign shared_output_pin_o = s.pin_o;
    assign shared_output_pin_oe = s.pin_oe;

    assign wave = tcm_pkg::tcm_wave_t'({s.ctrl[tcm_pkg::CTRL_WG1_BIT], s.ctrl[tcm_pkg::CTRL_WG0_BIT]});
    assign com = s.ctrl[tcm_pkg::CTRL_COM_HI:tcm_pkg::CTRL_COM_LO];
    assign do_write = s.aw_have && s.w_have && !s.bvalid;
    assign idx_known = (s.aw_idx >= tcm_pkg::IDX_FLAGS) && (s.aw_idx <= tcm_pkg::IDX_PORT);
    assign ar_idx = araddr[7:2];
    assign ar_known = (ar_idx >= tcm_pkg::IDX_FLAGS) && (ar_idx <= tcm_pkg::IDX_PORT);
    assign wr_count = do_write && s.w_lane0 && (s.aw_idx == tcm_pkg::IDX_COUNT);
    assign wr_ctrl = do_write && s.w_lane0 && (s.aw_idx == tcm_pkg::IDX_CTRL);
    assign match = (s.count == s.compare);
    assign cmp_event = tick && match && !s.block_cmp;
    assign force_cmp = wr_ctrl && s.w_byte[tcm_pkg::CTRL_FORCE_BIT] && !s.ctrl[tcm_pkg::CTRL_WG0_BIT];
    assign oc_en = (com != tcm_pkg::COM_OFF);
    assign mod_on = oc_en && wide_timer_compare_mode_on && !legacy_mode_fuse;

    always_comb begin
        next_s = s;
        ovf_event = 1'b0;
        // Write address and data are taken in either order, then written together.
        if (awvalid && s.awready) begin
            next_s.aw_have = 1'b1;
            next_s.aw_idx = awaddr[7:2];
        end
        if (wvalid && s.wready) begin
            next_s.w_have = 1'b1;
            next_s.w_byte = wdata[7:0];
            next_s.w_lane0 = wstrb[0];
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (do_write) begin
            next_s.aw_have = 1'b0;
            next_s.w_have = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = idx_known ? tcm_pkg::RESP_OKAY : tcm_pkg::RESP_SLVERR;
            if (s.w_lane0) begin
                case (s.aw_idx)
                    tcm_pkg::IDX_MASK: next_s.mask = s.w_byte;
                    tcm_pkg::IDX_CTRL: next_s.ctrl = s.w_byte & tcm_pkg::CTRL_WRITE_MASK;
                    tcm_pkg::IDX_COMPARE: next_s.compare = s.w_byte;
                    tcm_pkg::IDX_PORT: next_s.port = s.w_byte & tcm_pkg::PORT_WRITE_MASK;
                    default: next_s.mask = next_s.mask;
                endcase
            end
        end
        next_s.awready = !next_s.aw_have && !next_s.bvalid;
        next_s.wready = !next_s.w_have && !next_s.bvalid;
        // Reads answer one cycle after the address is taken.
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = ar_known ? tcm_pkg::RESP_OKAY : tcm_pkg::RESP_SLVERR;
            case (ar_idx)
                tcm_pkg::IDX_FLAGS: next_s.rdata = {24'h000000, s.flags};
                tcm_pkg::IDX_MASK: next_s.rdata = {24'h000000, s.mask};
                tcm_pkg::IDX_CTRL: next_s.rdata = {24'h000000, s.ctrl};
                tcm_pkg::IDX_COUNT: next_s.rdata = {24'h000000, s.count};
                tcm_pkg::IDX_COMPARE: next_s.rdata = {24'h000000, s.compare};
                tcm_pkg::IDX_PORT: next_s.rdata = {24'h000000, s.port};
                default: next_s.rdata = 32'h00000000;
            endcase
        end
        next_s.arready = !next_s.rvalid;
        // Counting sequence per waveform mode.
        if (tick) begin
            next_s.block_cmp = 1'b0;
            case (wave)
                tcm_pkg::WAVE_NORMAL, tcm_pkg::WAVE_FAST: begin
                    next_s.count = s.count + tcm_pkg::COUNT_ONE;
                    ovf_event = (s.count == tcm_pkg::COUNT_MAX);
                end
                tcm_pkg::WAVE_CTC: begin
                    next_s.count = match ? tcm_pkg::COUNT_BOTTOM : s.count + tcm_pkg::COUNT_ONE;
                    ovf_event = (s.count == tcm_pkg::COUNT_MAX);
                end
                tcm_pkg::WAVE_PHASE: begin
                    if (!s.count_down) begin
                        if (s.count == tcm_pkg::COUNT_MAX) begin
                            next_s.count_down = 1'b1;
                            next_s.count = s.count - tcm_pkg::COUNT_ONE;
                        end else begin
                            next_s.count = s.count + tcm_pkg::COUNT_ONE;
                        end
                    end else if (s.count == tcm_pkg::COUNT_BOTTOM) begin
                        next_s.count_down = 1'b0;
                        next_s.count = s.count + tcm_pkg::COUNT_ONE;
                        ovf_event = 1'b1;
                    end else begin
                        next_s.count = s.count - tcm_pkg::COUNT_ONE;
                    end
                end
                default: next_s.count = s.count;
            endcase
        end
        if (wr_count) begin
            next_s.count = s.w_byte;
            next_s.block_cmp = 1'b1;
        end
        // Compare output waveform.
        if (wave == tcm_pkg::WAVE_NORMAL || wave == tcm_pkg::WAVE_CTC) begin
            if (cmp_event || force_cmp) begin
                case (com)
                    tcm_pkg::COM_TOGGLE: next_s.oc = !s.oc;
                    tcm_pkg::COM_CLEAR: next_s.oc = 1'b0;
                    tcm_pkg::COM_SET: next_s.oc = 1'b1;
                    default: next_s.oc = s.oc;
                endcase
            end
        end else if (wave == tcm_pkg::WAVE_FAST) begin
            if (cmp_event && com[1]) begin
                next_s.oc = com[0];
            end
            if (tick && s.count == tcm_pkg::COUNT_MAX && com[1]) begin
                next_s.oc = !com[0];
            end
        end else begin
            if (cmp_event && com[1]) begin
                next_s.oc = com[0] ^ s.count_down;
            end
        end
        // Flags: a hardware event in the clearing cycle wins.
        next_s.flags[tcm_pkg::FLAG_CMP_BIT] = cmp_event || (s.flags[tcm_pkg::FLAG_CMP_BIT] &&
            !compare_vector_ack &&
            !(do_write && s.w_lane0 && s.aw_idx == tcm_pkg::IDX_FLAGS && s.w_byte[tcm_pkg::FLAG_CMP_BIT]));
        next_s.flags[tcm_pkg::FLAG_OVF_BIT] = ovf_event || (s.flags[tcm_pkg::FLAG_OVF_BIT] &&
            !overflow_vector_ack &&
            !(do_write && s.w_lane0 && s.aw_idx == tcm_pkg::IDX_FLAGS && s.w_byte[tcm_pkg::FLAG_OVF_BIT]));
        next_s.flags = next_s.flags & tcm_pkg::FLAG_WRITE_MASK;
        next_s.cmp_irq = s.mask[tcm_pkg::MASK_CMP_BIT] && global_irq_enable && s.flags[tcm_pkg::FLAG_CMP_BIT];
        next_s.ovf_irq = s.mask[tcm_pkg::MASK_OVF_BIT] && global_irq_enable && s.flags[tcm_pkg::FLAG_OVF_BIT];
        // Shared pin: modulated, single compare output, wide timer channel C output, or port latch.
        if (mod_on) begin
            if (s.port[tcm_pkg::PORT_LATCH_BIT]) begin
                next_s.pin_o = s.oc || wide_timer_channel_c_output;
            end else begin
                next_s.pin_o = s.oc && wide_timer_channel_c_output;
            end
        end else if (oc_en) begin
            next_s.pin_o = s.oc;
        end else if (wide_timer_compare_mode_on) begin
            next_s.pin_o = wide_timer_channel_c_output;
        end else begin
            next_s.pin_o = s.port[tcm_pkg::PORT_LATCH_BIT];
        end
        next_s.pin_oe = s.port[tcm_pkg::PORT_DIR_BIT];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    cmp_irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        compare_irq_req == $past(s.mask[7] && global_irq_enable && s.flags[7]))
        else $error("Compare interrupt request does not follow enable and flag.");
    ovf_irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 overflow_irq_req == $past(s.mask[6] && global_irq_enable && s.flags[6]))
        else $error("Overflow interrupt request does not follow enable and flag.");
    cmp_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && s.count == s.compare && !s.block_cmp |=> s.flags[7])
        else $error("Compare match did not set the compare flag.");
    cmp_flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        compare_vector_ack && !cmp_event |=> !s.flags[7])
        else $error("Vector execution did not clear the compare flag.");
    count_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s.block_cmp && tick |=> !$rose(s.flags[7]))
        else $error("Compare match was not blocked after a counter write.");
    phase_ovf_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && wave == tcm_pkg::WAVE_PHASE && s.count_down && s.count == 8'h00 |=> s.flags[6] && !s.count_down)
        else $error("Phase correct reversal at bottom did not set overflow.");
    pin_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 shared_output_pin_oe == $past(s.port[1]))
        else $error("Pin direction does not follow the direction bit.");
    mod_and_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mod_on && !s.port[0] |=> shared_output_pin_o == $past(s.oc && wide_timer_channel_c_output))
        else $error("Modulator with latch low is not an AND.");
    legacy_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        legacy_mode_fuse && oc_en |=> shared_output_pin_o == $past(s.oc))
        else $error("Modulator active under the legacy fuse.");
    toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cmp_event && wave == tcm_pkg::WAVE_NORMAL && com == 2'b01 |=> s.oc != $past(s.oc))
        else $error("Toggle mode did not toggle on a compare match.");
endmodule : tcm_timer

// ### rtl/tcm_pkg.sv
// Shared constants and types of the timer with compare modulator.
package tcm_pkg;
    localparam int IDX_W = 6;
    localparam logic [5:0] IDX_FLAGS = 6'h36;
    localparam logic [5:0] IDX_MASK = 6'h37;
    localparam logic [5:0] IDX_CTRL = 6'h38;
    localparam logic [5:0] IDX_COUNT = 6'h39;
    localparam logic [5:0] IDX_COMPARE = 6'h3A;
    localparam logic [5:0] IDX_PORT = 6'h3B;
    localparam int FLAG_CMP_BIT = 7;
    localparam int FLAG_OVF_BIT = 6;
    localparam int MASK_CMP_BIT = 7;
    localparam int MASK_OVF_BIT = 6;
    localparam int CTRL_FORCE_BIT = 7;
    localparam int CTRL_WG0_BIT = 6;
    localparam int CTRL_COM_HI = 5;
    localparam int CTRL_COM_LO = 4;
    localparam int CTRL_WG1_BIT = 3;
    localparam int CTRL_CS_HI = 2;
    localparam int CTRL_CS_LO = 0;
    localparam int PORT_LATCH_BIT = 0;
    localparam int PORT_DIR_BIT = 1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h7F;
    localparam logic [7:0] FLAG_WRITE_MASK = 8'hC0;
    localparam logic [7:0] PORT_WRITE_MASK = 8'h03;
    localparam logic [1:0] COM_OFF = 2'b00;
    localparam logic [1:0] COM_TOGGLE = 2'b01;
    localparam logic [1:0] COM_CLEAR = 2'b10;
    localparam logic [1:0] COM_SET = 2'b11;
    localparam int PRE_W = 10;
    localparam int DIV8_BITS = 3;
    localparam int DIV64_BITS = 6;
    localparam int DIV256_BITS = 8;
    localparam int DIV1024_BITS = 10;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        CS_STOP = 3'b000,
        CS_DIV1 = 3'b001,
        CS_DIV8 = 3'b010,
        CS_DIV64 = 3'b011,
        CS_DIV256 = 3'b100,
        CS_DIV1024 = 3'b101,
        CS_EXT_FALL = 3'b110,
        CS_EXT_RISE = 3'b111
    } tcm_clk_sel_t;
    typedef enum logic [1:0] {
        WAVE_NORMAL = 2'b00,
        WAVE_PHASE = 2'b01,
        WAVE_CTC = 2'b10,
        WAVE_FAST = 2'b11
    } tcm_wave_t;
endpackage : tcm_pkg

// ### rtl/tcm_clk_sel.sv
// Timer tick source: prescaler taps and external count edge detection.
`timescale 1ns/1ns
module tcm_clk_sel (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] clock_select,
    input wire logic external_count_input,
    output logic count_tick
);
    typedef struct packed {
        logic [tcm_pkg::PRE_W-1:0] pre;
        logic sync1;
        logic sync2;
        logic sync3;
        logic tick;
    } tcm_sel_state_t;

    tcm_sel_state_t s;
    tcm_sel_state_t next_s;
    logic rise;
    logic fall;

    assign rise = s.sync2 & ~s.sync3;
    assign fall = ~s.sync2 & s.sync3;
    assign count_tick = s.tick;

    always_comb begin
        next_s = s;
        next_s.pre = s.pre + 10'h001;
        next_s.sync1 = external_count_input;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        case (tcm_pkg::tcm_clk_sel_t'(clock_select))
            tcm_pkg::CS_STOP: next_s.tick = 1'b0;
            tcm_pkg::CS_DIV1: next_s.tick = 1'b1;
            tcm_pkg::CS_DIV8: next_s.tick = &s.pre[tcm_pkg::DIV8_BITS-1:0];
            tcm_pkg::CS_DIV64: next_s.tick = &s.pre[tcm_pkg::DIV64_BITS-1:0];
            tcm_pkg::CS_DIV256: next_s.tick = &s.pre[tcm_pkg::DIV256_BITS-1:0];
            tcm_pkg::CS_DIV1024: next_s.tick = &s.pre[tcm_pkg::DIV1024_BITS-1:0];
            tcm_pkg::CS_EXT_FALL: next_s.tick = fall;
            tcm_pkg::CS_EXT_RISE: next_s.tick = rise;
            default: next_s.tick = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    stopped_no_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clock_select == 3'b000) |=> !count_tick)
        else $error("Tick seen while the timer clock is stopped.");
    undivided_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clock_select == 3'b001) |=> count_tick)
        else $error("Undivided clock select did not tick every cycle.");
    rise_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clock_select == 3'b111) && $rose(s.sync2) |=> count_tick)
        else $error("Rising external edge did not produce a tick.");
endmodule : tcm_clk_sel

// ### tb/tcm_far_model.sv
// Far-side model: software that drives the external count pin.
`timescale 1ns/1ns
module tcm_far_model (
    input wire logic aclk,
    output logic external_count_input
);
    initial begin
        external_count_input = 1'h0;
    end
    // Toggles the pin n times, thirteen cycles apart, as port writes of software would.
    task automatic toggle_pin(input int n);
        repeat (n) begin
            @(posedge aclk);
            external_count_input <= ~external_count_input;
            repeat (12) @(posedge aclk);
        end
    endtask : toggle_pin
endmodule : tcm_far_model

// ### tb/tb.sv
// Self-checking bench of the timer with compare modulator.
`timescale 1ns/1ns
module tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic global_irq_enable = 1'h0, compare_vector_ack = 1'h0, overflow_vector_ack = 1'h0;
    logic legacy_mode_fuse = 1'h0, wide_timer_channel_c_output = 1'h0, wide_timer_compare_mode_on = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, compare_irq_req, overflow_irq_req;
    logic compare_wave_output, shared_output_pin_o, shared_output_pin_oe, external_count_input;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int miscompares = 0;
    int comparisons = 0;
    always #25 aclk = ~aclk;
    tcm_timer #(.ADDR_W(8)) tcm_timer_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .global_irq_enable(global_irq_enable), .compare_vector_ack(compare_vector_ack),
        .overflow_vector_ack(overflow_vector_ack), .legacy_mode_fuse(legacy_mode_fuse),
        .wide_timer_channel_c_output(wide_timer_channel_c_output),
        .wide_timer_compare_mode_on(wide_timer_compare_mode_on), .external_count_input(external_count_input),
        .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req),
        .compare_wave_output(compare_wave_output), .shared_output_pin_o(shared_output_pin_o),
        .shared_output_pin_oe(shared_output_pin_oe));
    tcm_far_model tcm_far_model_inst (.aclk(aclk), .external_count_input(external_count_input));

    task automatic end_sim();
        $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic give_up();
        miscompares++;
        end_sim();
    endtask : give_up
    task automatic bus_write(input logic [5:0] idx, input logic [7:0] val, input logic [1:0] er = 2'h0);
        int n;
        logic a, w, b;
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, val};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 200; n++) begin
            @(negedge aclk);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid && bready;
            if (b) check(32'(bresp), 32'(er));
            @(posedge aclk);
            if (a) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
            if (b) begin
                bready <= 1'h0;
                break;
            end
        end
        if (n == 200) give_up();
    endtask : bus_write
    task automatic bus_read(input logic [5:0] idx, output logic [31:0] d, input logic [1:0] er = 2'h0);
        int n;
        logic a, r;
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 200; n++) begin
            @(negedge aclk);
            a = arvalid && arready;
            r = rvalid && rready;
            d = rdata;
            if (r) check(32'(rresp), 32'(er));
            @(posedge aclk);
            if (a) arvalid <= 1'h0;
            if (r) begin
                rready <= 1'h0;
                break;
            end
        end
        if (n == 200) give_up();
    endtask : bus_read
    task automatic t_regs();
        logic [31:0] d;
        logic [5:0] idx [4] = '{tcm_pkg::IDX_FLAGS, tcm_pkg::IDX_MASK, tcm_pkg::IDX_COUNT, tcm_pkg::IDX_COMPARE};
        for (int i = 0; i < 4; i++) begin
            bus_read(idx[i], d);
            check(d, 32'h0);
            bus_write(idx[i], 8'hA5);
            bus_read(idx[i], d);
            check(d, (i == 0) ? 32'h0 : 32'hA5);
        end
        bus_write(6'h00, 8'h11, tcm_pkg::RESP_SLVERR);
        bus_read(6'h00, d, tcm_pkg::RESP_SLVERR);
        check(d, 32'h0);
        $display("Register test done");
    endtask : t_regs
    task automatic run_ticks(input logic [7:0] start, input logic [31:0] flags, input logic wave);
        logic [31:0] d;
        bus_write(tcm_pkg::IDX_COUNT, start);
        bus_write(tcm_pkg::IDX_CTRL, 8'h11);
        repeat (20) @(posedge aclk);
        bus_write(tcm_pkg::IDX_CTRL, 8'h10);
        bus_read(tcm_pkg::IDX_FLAGS, d);
        check(d, flags);
        @(negedge aclk);
        check(32'(compare_wave_output), 32'(wave));
        check(32'(compare_irq_req), 32'(flags[7]));
        check(32'(overflow_irq_req), 32'(flags[6]));
    endtask : run_ticks
    task automatic t_flags();
        logic [31:0] d;
        bus_write(tcm_pkg::IDX_MASK, 8'hC0);
        bus_write(tcm_pkg::IDX_COMPARE, 8'h20);
        global_irq_enable <= 1'h1;
        run_ticks(8'h1C, 32'h80, 1'h1);
        global_irq_enable <= 1'h0;
        repeat (3) @(negedge aclk);
        check(32'(compare_irq_req), 32'h0);
        global_irq_enable <= 1'h1;
        bus_write(tcm_pkg::IDX_FLAGS, 8'h80);
        bus_read(tcm_pkg::IDX_FLAGS, d);
        check(d, 32'h0);
        run_ticks(8'h20, 32'h0, 1'h1);
        run_ticks(8'hFA, 32'h40, 1'h1);
        overflow_vector_ack <= 1'h1;
        @(posedge aclk);
        overflow_vector_ack <= 1'h0;
        run_ticks(8'h1C, 32'h80, 1'h0);
        compare_vector_ack <= 1'h1;
        @(posedge aclk);
        compare_vector_ack <= 1'h0;
        bus_read(tcm_pkg::IDX_FLAGS, d);
        check(d, 32'h0);
        $display("Flag test done");
    endtask : t_flags
    task automatic t_mod();
        logic [5:0] m;
        logic [2:0] k;
        logic ow, e;
        ow = 1'h0;
        for (m = 6'h00; m < 6'h20; m++) begin
            for (k = 3'h0; k < 3'h4; k++) begin
                if (ow !== k[1]) begin
                    bus_write(tcm_pkg::IDX_CTRL, 8'h10);
                    bus_write(tcm_pkg::IDX_CTRL, 8'h90);
                    ow = k[1];
                end
                bus_write(tcm_pkg::IDX_CTRL, m[3] ? 8'h10 : 8'h00);
                bus_write(tcm_pkg::IDX_PORT, {6'h00, m[0], m[1]});
                wide_timer_compare_mode_on <= m[2];
                wide_timer_channel_c_output <= k[0];
                legacy_mode_fuse <= m[4];
                repeat (3) @(posedge aclk);
                @(negedge aclk);
                if (m[3] && m[2] && !m[4]) e = m[1] ? (ow | k[0]) : (ow & k[0]);
                else if (m[3]) e = ow;
                else if (m[2]) e = k[0];
                else e = m[1];
                check(32'(shared_output_pin_o), 32'(e));
                check(32'(shared_output_pin_oe), 32'(m[0]));
                check(32'(compare_wave_output), 32'(ow));
            end
        end
        $display("Modulator test done");
    endtask : t_mod
    task automatic t_prescale();
        logic [31:0] d;
        logic [7:0] a, dl;
        int sh [6] = '{0, 0, 3, 6, 8, 10};
        for (int c = 0; c < 6; c++) begin
            bus_write(tcm_pkg::IDX_CTRL, 8'(c));
            bus_read(tcm_pkg::IDX_COUNT, d);
            a = d[7:0];
            repeat ((16 << sh[c]) - 3) @(posedge aclk);
            bus_read(tcm_pkg::IDX_COUNT, d);
            dl = d[7:0] - a;
            check(32'(dl), (c == 0) ? 32'h0 : 32'h10);
        end
        $display("Prescaler test done");
    endtask : t_prescale
    task automatic t_phase();
        logic [31:0] d;
        bus_write(tcm_pkg::IDX_CTRL, 8'h40);
        bus_write(tcm_pkg::IDX_FLAGS, 8'hC0);
        bus_write(tcm_pkg::IDX_COUNT, 8'hFD);
        bus_write(tcm_pkg::IDX_CTRL, 8'h41);
        repeat (300) @(posedge aclk);
        bus_write(tcm_pkg::IDX_CTRL, 8'h40);
        bus_read(tcm_pkg::IDX_FLAGS, d);
        check(d, 32'hC0);
        $display("Phase test done");
    endtask : t_phase
    task automatic ext_count(input logic [7:0] ctrl, input int toggles, input logic [7:0] exp);
        logic [31:0] d;
        logic [7:0] a, dl;
        bus_write(tcm_pkg::IDX_CTRL, ctrl);
        bus_read(tcm_pkg::IDX_COUNT, d);
        a = d[7:0];
        tcm_far_model_inst.toggle_pin(toggles);
        repeat (8) @(posedge aclk);
        bus_read(tcm_pkg::IDX_COUNT, d);
        dl = d[7:0] - a;
        check(32'(dl), 32'(exp));
    endtask : ext_count
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs();
        t_flags();
        t_mod();
        t_prescale();
        t_phase();
        ext_count(8'h07, 3, 8'h02);
        ext_count(8'h06, 2, 8'h01);
        $display("External count test done");
        end_sim();
    end
endmodule : tb
